// ---- ryc_defs.vh ----
`ifndef RYC_DEFS_VH
`define RYC_DEFS_VH

`define RYC_INPUT_WIDTH    8
`define RYC_OUTPUT_WIDTH   8
`define RYC_INTERNAL_WIDTH 18
`define RYC_COEF_WIDTH     17
`define RYC_UPPER_SAT      1
`define RYC_LOWER_SAT      1
`define RYC_LATENCY        5

`define RYC_ADDR_RED_COEF     8'h00
`define RYC_ADDR_BLUE_COEF    8'h04
`define RYC_ADDR_CB_COEF      8'h08
`define RYC_ADDR_CR_COEF      8'h0c
`define RYC_ADDR_LUMA_OFS     8'h10
`define RYC_ADDR_CB_OFS       8'h14
`define RYC_ADDR_CR_OFS       8'h18
`define RYC_ADDR_LUMA_UPPER   8'h1c
`define RYC_ADDR_LUMA_LOWER   8'h20
`define RYC_ADDR_CHROMA_UPPER 8'h24
`define RYC_ADDR_CHROMA_LOWER 8'h28
`define RYC_ADDR_STATUS       8'h2c

`define RYC_RST_RED_COEF     17'h0_4c8b
`define RYC_RST_BLUE_COEF    17'h0_1d2f
`define RYC_RST_CB_COEF      17'h0_9062
`define RYC_RST_CR_COEF      17'h0_b687
`define RYC_RST_LUMA_OFS     16'h0000
`define RYC_RST_CHROMA_OFS   16'h0080
`define RYC_RST_UPPER_LIMIT  16'h00ff
`define RYC_RST_LOWER_LIMIT  16'h0000

`endif

// ---- ryc_round.v ----
`timescale 1ns/10ps
module ryc_round
#(
   parameter W_IN = 16,
   parameter DROP = 1
)
(
   // Value to round.
   input  wire signed [W_IN-1:0] valueIn,
   // Rounded value, one guard bit wider than the kept bits.
   output wire signed [W_IN-DROP:0] valueOut
);

   generate
      if (DROP == 0)
      begin : g_pass
         assign valueOut = {valueIn[W_IN-1], valueIn};
      end
      else
      begin : g_round
         localparam [W_IN:0] HALF = {{W_IN{1'b0}}, 1'b1} << (DROP - 1);
         wire signed [W_IN:0] extended;
         wire signed [W_IN:0] biased;
         assign extended = {valueIn[W_IN-1], valueIn};
         assign biased   = extended + $signed(HALF);
         assign valueOut = biased[W_IN:DROP];
      end
   endgenerate

endmodule

// ---- ryc_clamp.v ----
`timescale 1ns/10ps
module ryc_clamp
#(
   parameter W_IN      = 20,
   parameter OUT_W     = 8,
   parameter UPPER_SAT = 1,
   parameter LOWER_SAT = 1
)
(
   // Full-width signed result.
   input  wire signed [W_IN-1:0]  valueIn,
   // Bounds.
   input  wire        [OUT_W-1:0] upperLimit,
   input  wire        [OUT_W-1:0] lowerLimit,
   // Bounded or wrapped result.
   output reg         [OUT_W-1:0] valueOut
);

   wire signed [W_IN-1:0] upperExt;
   wire signed [W_IN-1:0] lowerExt;

   assign upperExt = $signed({{(W_IN-OUT_W){1'b0}}, upperLimit});
   assign lowerExt = $signed({{(W_IN-OUT_W){1'b0}}, lowerLimit});

   always @*
   begin
      valueOut = valueIn[OUT_W-1:0];
      if (UPPER_SAT == 1 && valueIn > upperExt)
      begin
         valueOut = upperLimit;
      end
      if (LOWER_SAT == 1 && valueIn < lowerExt)
      begin
         valueOut = lowerLimit;
      end
   end

endmodule

// ---- ryc_converter.v ----
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "ryc_defs.vh"
module ryc_converter
#(
   parameter IN_W      = `RYC_INPUT_WIDTH,
   parameter OUT_W     = `RYC_OUTPUT_WIDTH,
   parameter INT_W     = `RYC_INTERNAL_WIDTH,
   parameter COEF_W    = `RYC_COEF_WIDTH,
   parameter UPPER_SAT = `RYC_UPPER_SAT,
   parameter LOWER_SAT = `RYC_LOWER_SAT
)
(
   // Clock and reset.
   input  wire             ref_clk,
   input  wire             resetn,
   // Register port.
   input  wire [7:0]       regAddr,
   input  wire [31:0]      regWriteData,
   input  wire             regWrite,
   input  wire             regRead,
   output reg  [31:0]      regReadData,
   // Pixel input.
   input  wire             pixValidIn,
   input  wire [IN_W-1:0]  redIn,
   input  wire [IN_W-1:0]  greenIn,
   input  wire [IN_W-1:0]  blueIn,
   // Pixel output.
   output reg              pixValidOut,
   output reg  [OUT_W-1:0] lumaOut,
   output reg  [OUT_W-1:0] cbOut,
   output reg  [OUT_W-1:0] crOut
);

   localparam FRAC   = COEF_W - 1;
   localparam FR     = INT_W - 2 - IN_W;
   localparam DW     = IN_W + 1;
   localparam PW     = DW + COEF_W + 1;
   localparam SW     = PW + 1;
   localparam DROP_S = FRAC - FR;
   localparam RSW    = SW - DROP_S + 1;
   localparam YW     = RSW + 1;
   localparam DROP_Y = INT_W - 2 - OUT_W;
   localparam CPW    = YW + COEF_W + 1;
   localparam DROP_C = FRAC + DROP_Y;
   localparam YRW    = YW - DROP_Y + 1;
   localparam CRW    = CPW - DROP_C + 1;
   localparam OW     = CRW + 2;

   // Register file.
   reg        [COEF_W-1:0] redCoef_q;
   reg        [COEF_W-1:0] blueCoef_q;
   reg        [COEF_W-1:0] cbCoef_q;
   reg        [COEF_W-1:0] crCoef_q;
   reg        [15:0]       lumaOfs_q;
   reg        [15:0]       cbOfs_q;
   reg        [15:0]       crOfs_q;
   reg        [15:0]       lumaUpper_q;
   reg        [15:0]       lumaLower_q;
   reg        [15:0]       chromaUpper_q;
   reg        [15:0]       chromaLower_q;
   reg        [15:0]       pixCount_q;
   reg        [31:0]       readData_d;

   // Pipeline stage 1.
   reg                     valid1_q;
   reg signed [DW-1:0]     rMinusG_q;
   reg signed [DW-1:0]     bMinusG_q;
   reg        [IN_W-1:0]   red1_q;
   reg        [IN_W-1:0]   green1_q;
   reg        [IN_W-1:0]   blue1_q;
   // Pipeline stage 2.
   reg                     valid2_q;
   reg signed [PW-1:0]     prodRed_q;
   reg signed [PW-1:0]     prodBlue_q;
   reg        [IN_W-1:0]   red2_q;
   reg        [IN_W-1:0]   green2_q;
   reg        [IN_W-1:0]   blue2_q;
   // Pipeline stage 3.
   reg                     valid3_q;
   reg signed [YW-1:0]     yRaw3_q;
   reg        [IN_W-1:0]   red3_q;
   reg        [IN_W-1:0]   blue3_q;
   // Pipeline stage 4.
   reg                     valid4_q;
   reg signed [YW-1:0]     yRaw4_q;
   reg signed [CPW-1:0]    cbProd_q;
   reg signed [CPW-1:0]    crProd_q;

   wire signed [DW-1:0]    rMinusG_d;
   wire signed [DW-1:0]    bMinusG_d;
   wire signed [COEF_W:0]  redCoefS;
   wire signed [COEF_W:0]  blueCoefS;
   wire signed [COEF_W:0]  cbCoefS;
   wire signed [COEF_W:0]  crCoefS;
   wire signed [PW-1:0]    prodRed_d;
   wire signed [PW-1:0]    prodBlue_d;
   wire signed [SW-1:0]    diffSum;
   wire signed [RSW-1:0]   diffRounded;
   wire signed [YW-1:0]    greenScaled;
   wire signed [YW-1:0]    redScaled;
   wire signed [YW-1:0]    blueScaled;
   wire signed [YW-1:0]    yRaw_d;
   wire signed [YW-1:0]    cbDiff;
   wire signed [YW-1:0]    crDiff;
   wire signed [CPW-1:0]   cbProd_d;
   wire signed [CPW-1:0]   crProd_d;
   wire signed [YRW-1:0]   yRounded;
   wire signed [CRW-1:0]   cbRounded;
   wire signed [CRW-1:0]   crRounded;
   wire signed [OW-1:0]    yFull;
   wire signed [OW-1:0]    cbFull;
   wire signed [OW-1:0]    crFull;
   wire        [OUT_W-1:0] yBounded;
   wire        [OUT_W-1:0] cbBounded;
   wire        [OUT_W-1:0] crBounded;

   // Zero-extends an output-domain offset to the offset adder width.
   function [OW-1:0] ofsExt;
      input [15:0] ofs;
      begin
         ofsExt = {{(OW-OUT_W){1'b0}}, ofs[OUT_W-1:0]};
      end
   endfunction

   // Places an input sample on the intermediate luma scale.
   function [YW-1:0] sampleScale;
      input [IN_W-1:0] sample;
      begin
         sampleScale = {{(YW-IN_W-FR){1'b0}}, sample, {FR{1'b0}}};
      end
   endfunction

   // Register writes.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         redCoef_q     <= `RYC_RST_RED_COEF;
         blueCoef_q    <= `RYC_RST_BLUE_COEF;
         cbCoef_q      <= `RYC_RST_CB_COEF;
         crCoef_q      <= `RYC_RST_CR_COEF;
         lumaOfs_q     <= `RYC_RST_LUMA_OFS;
         cbOfs_q       <= `RYC_RST_CHROMA_OFS;
         crOfs_q       <= `RYC_RST_CHROMA_OFS;
         lumaUpper_q   <= `RYC_RST_UPPER_LIMIT;
         lumaLower_q   <= `RYC_RST_LOWER_LIMIT;
         chromaUpper_q <= `RYC_RST_UPPER_LIMIT;
         chromaLower_q <= `RYC_RST_LOWER_LIMIT;
      end
      else if (regWrite)
      begin
         case (regAddr)
            `RYC_ADDR_RED_COEF     : redCoef_q     <= regWriteData[COEF_W-1:0];
            `RYC_ADDR_BLUE_COEF    : blueCoef_q    <= regWriteData[COEF_W-1:0];
            `RYC_ADDR_CB_COEF      : cbCoef_q      <= regWriteData[COEF_W-1:0];
            `RYC_ADDR_CR_COEF      : crCoef_q      <= regWriteData[COEF_W-1:0];
            `RYC_ADDR_LUMA_OFS     : lumaOfs_q     <= regWriteData[15:0];
            `RYC_ADDR_CB_OFS       : cbOfs_q       <= regWriteData[15:0];
            `RYC_ADDR_CR_OFS       : crOfs_q       <= regWriteData[15:0];
            `RYC_ADDR_LUMA_UPPER   : lumaUpper_q   <= regWriteData[15:0];
            `RYC_ADDR_LUMA_LOWER   : lumaLower_q   <= regWriteData[15:0];
            `RYC_ADDR_CHROMA_UPPER : chromaUpper_q <= regWriteData[15:0];
            `RYC_ADDR_CHROMA_LOWER : chromaLower_q <= regWriteData[15:0];
            default                : ;
         endcase
      end
   end

   // Register read mux.
   always @*
   begin
      case (regAddr)
         `RYC_ADDR_RED_COEF     : readData_d = {{(32-COEF_W){1'b0}}, redCoef_q};
         `RYC_ADDR_BLUE_COEF    : readData_d = {{(32-COEF_W){1'b0}}, blueCoef_q};
         `RYC_ADDR_CB_COEF      : readData_d = {{(32-COEF_W){1'b0}}, cbCoef_q};
         `RYC_ADDR_CR_COEF      : readData_d = {{(32-COEF_W){1'b0}}, crCoef_q};
         `RYC_ADDR_LUMA_OFS     : readData_d = {16'h0000, lumaOfs_q};
         `RYC_ADDR_CB_OFS       : readData_d = {16'h0000, cbOfs_q};
         `RYC_ADDR_CR_OFS       : readData_d = {16'h0000, crOfs_q};
         `RYC_ADDR_LUMA_UPPER   : readData_d = {16'h0000, lumaUpper_q};
         `RYC_ADDR_LUMA_LOWER   : readData_d = {16'h0000, lumaLower_q};
         `RYC_ADDR_CHROMA_UPPER : readData_d = {16'h0000, chromaUpper_q};
         `RYC_ADDR_CHROMA_LOWER : readData_d = {16'h0000, chromaLower_q};
         `RYC_ADDR_STATUS       : readData_d = {16'h0000, pixCount_q};
         default                : readData_d = 32'h0000_0000;
      endcase
   end

   // Read data stand for exactly one cycle after the strobe.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         regReadData <= 32'h0000_0000;
      end
      else if (regRead)
      begin
         regReadData <= readData_d;
      end
      else
      begin
         regReadData <= 32'h0000_0000;
      end
   end

   // Colour differences.
   assign rMinusG_d = $signed({1'b0, redIn}) - $signed({1'b0, greenIn});
   assign bMinusG_d = $signed({1'b0, blueIn}) - $signed({1'b0, greenIn});

   // Coefficients as positive signed multiplicands.
   assign redCoefS  = $signed({1'b0, redCoef_q});
   assign blueCoefS = $signed({1'b0, blueCoef_q});
   assign cbCoefS   = $signed({1'b0, cbCoef_q});
   assign crCoefS   = $signed({1'b0, crCoef_q});

   assign prodRed_d  = rMinusG_q * redCoefS;
   assign prodBlue_d = bMinusG_q * blueCoefS;

   // Intermediate luma.
   assign diffSum = {prodRed_q[PW-1], prodRed_q} + {prodBlue_q[PW-1], prodBlue_q};

   ryc_round #(.W_IN(SW), .DROP(DROP_S)) uRoundDiff
   (
      .valueIn  (diffSum),
      .valueOut (diffRounded)
   );

   assign greenScaled = $signed(sampleScale(green2_q));
   assign yRaw_d      = {diffRounded[RSW-1], diffRounded} + greenScaled;

   // Chroma products.
   assign redScaled  = $signed(sampleScale(red3_q));
   assign blueScaled = $signed(sampleScale(blue3_q));
   assign cbDiff     = blueScaled - yRaw3_q;
   assign crDiff     = redScaled - yRaw3_q;
   assign cbProd_d   = cbDiff * cbCoefS;
   assign crProd_d   = crDiff * crCoefS;

   // Output rounding.
   ryc_round #(.W_IN(YW), .DROP(DROP_Y)) uRoundLuma
   (
      .valueIn  (yRaw4_q),
      .valueOut (yRounded)
   );

   ryc_round #(.W_IN(CPW), .DROP(DROP_C)) uRoundCb
   (
      .valueIn  (cbProd_q),
      .valueOut (cbRounded)
   );

   ryc_round #(.W_IN(CPW), .DROP(DROP_C)) uRoundCr
   (
      .valueIn  (crProd_q),
      .valueOut (crRounded)
   );

   // Offsets are added after rounding.
   assign yFull  = {{(OW-YRW){yRounded[YRW-1]}}, yRounded} + $signed(ofsExt(lumaOfs_q));
   assign cbFull = {{(OW-CRW){cbRounded[CRW-1]}}, cbRounded} + $signed(ofsExt(cbOfs_q));
   assign crFull = {{(OW-CRW){crRounded[CRW-1]}}, crRounded} + $signed(ofsExt(crOfs_q));

   // Bounding stage.
   ryc_clamp #(.W_IN(OW), .OUT_W(OUT_W), .UPPER_SAT(UPPER_SAT), .LOWER_SAT(LOWER_SAT)) uClampY
   (
      .valueIn    (yFull),
      .upperLimit (lumaUpper_q[OUT_W-1:0]),
      .lowerLimit (lumaLower_q[OUT_W-1:0]),
      .valueOut   (yBounded)
   );

   ryc_clamp #(.W_IN(OW), .OUT_W(OUT_W), .UPPER_SAT(UPPER_SAT), .LOWER_SAT(LOWER_SAT)) uClampCb
   (
      .valueIn    (cbFull),
      .upperLimit (chromaUpper_q[OUT_W-1:0]),
      .lowerLimit (chromaLower_q[OUT_W-1:0]),
      .valueOut   (cbBounded)
   );

   ryc_clamp #(.W_IN(OW), .OUT_W(OUT_W), .UPPER_SAT(UPPER_SAT), .LOWER_SAT(LOWER_SAT)) uClampCr
   (
      .valueIn    (crFull),
      .upperLimit (chromaUpper_q[OUT_W-1:0]),
      .lowerLimit (chromaLower_q[OUT_W-1:0]),
      .valueOut   (crBounded)
   );

   // Five-stage pipeline; every pixel advances one stage per clock.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         valid1_q    <= 1'b0;
         valid2_q    <= 1'b0;
         valid3_q    <= 1'b0;
         valid4_q    <= 1'b0;
         pixValidOut <= 1'b0;
         rMinusG_q   <= {DW{1'b0}};
         bMinusG_q   <= {DW{1'b0}};
         red1_q      <= {IN_W{1'b0}};
         green1_q    <= {IN_W{1'b0}};
         blue1_q     <= {IN_W{1'b0}};
         prodRed_q   <= {PW{1'b0}};
         prodBlue_q  <= {PW{1'b0}};
         red2_q      <= {IN_W{1'b0}};
         green2_q    <= {IN_W{1'b0}};
         blue2_q     <= {IN_W{1'b0}};
         yRaw3_q     <= {YW{1'b0}};
         red3_q      <= {IN_W{1'b0}};
         blue3_q     <= {IN_W{1'b0}};
         yRaw4_q     <= {YW{1'b0}};
         cbProd_q    <= {CPW{1'b0}};
         crProd_q    <= {CPW{1'b0}};
         lumaOut     <= {OUT_W{1'b0}};
         cbOut       <= {OUT_W{1'b0}};
         crOut       <= {OUT_W{1'b0}};
      end
      else
      begin
         valid1_q    <= pixValidIn;
         valid2_q    <= valid1_q;
         valid3_q    <= valid2_q;
         valid4_q    <= valid3_q;
         pixValidOut <= valid4_q;
         rMinusG_q   <= rMinusG_d;
         bMinusG_q   <= bMinusG_d;
         red1_q      <= redIn;
         green1_q    <= greenIn;
         blue1_q     <= blueIn;
         prodRed_q   <= prodRed_d;
         prodBlue_q  <= prodBlue_d;
         red2_q      <= red1_q;
         green2_q    <= green1_q;
         blue2_q     <= blue1_q;
         yRaw3_q     <= yRaw_d;
         red3_q      <= red2_q;
         blue3_q     <= blue2_q;
         yRaw4_q     <= yRaw3_q;
         cbProd_q    <= cbProd_d;
         crProd_q    <= crProd_d;
         lumaOut     <= yBounded;
         cbOut       <= cbBounded;
         crOut       <= crBounded;
      end
   end

   // Count of pixels delivered; a write to the status word clears it unless a pixel is counted in the same cycle.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         pixCount_q <= 16'h0000;
      end
      else if (valid4_q)
      begin
         pixCount_q <= pixCount_q + 16'h0001;
      end
      else if (regWrite && regAddr == `RYC_ADDR_STATUS)
      begin
         pixCount_q <= 16'h0000;
      end
   end

endmodule

// ---- ryc_converter_assertions.sv ----
`timescale 1ns/10ps
module ryc_converter_assertions
#(
   parameter IN_W      = 8,
   parameter OUT_W     = 8,
   parameter UPPER_SAT = 1,
   parameter LOWER_SAT = 1
)
(
   // Clock and reset.
   input wire             ref_clk,
   input wire             resetn,
   // Register port.
   input wire [7:0]       regAddr,
   input wire [31:0]      regWriteData,
   input wire             regWrite,
   input wire             regRead,
   input wire [31:0]      regReadData,
   // Pixel stream.
   input wire             pixValidIn,
   input wire             pixValidOut,
   input wire [OUT_W-1:0] lumaOut,
   input wire [OUT_W-1:0] cbOut,
   input wire [OUT_W-1:0] crOut
);
   reg [OUT_W-1:0] lumaHi_q;
   reg [OUT_W-1:0] lumaLo_q;
   reg [OUT_W-1:0] chromaHi_q;
   reg [OUT_W-1:0] chromaLo_q;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Shadow copies of the limit registers follow software writes.
   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         lumaHi_q   <= {OUT_W{1'b1}};
         lumaLo_q   <= {OUT_W{1'b0}};
         chromaHi_q <= {OUT_W{1'b1}};
         chromaLo_q <= {OUT_W{1'b0}};
      end
      else if (regWrite)
      begin
         if (regAddr == 8'h1c) lumaHi_q <= regWriteData[OUT_W-1:0];
         if (regAddr == 8'h20) lumaLo_q <= regWriteData[OUT_W-1:0];
         if (regAddr == 8'h24) chromaHi_q <= regWriteData[OUT_W-1:0];
         if (regAddr == 8'h28) chromaLo_q <= regWriteData[OUT_W-1:0];
      end
   end

   a_read_idle_zero: assert property (!regRead |=> regReadData == 32'h0000_0000)
      else $error("read data not zero outside a read answer");
   a_coef_upper_zero: assert property (regRead && regAddr <= 8'h0c |=> regReadData[31:17] == 15'h0000)
      else $error("coefficient read shows bits above 17");
   a_coef_readback: assert property (regWrite && regAddr == 8'h00 ##1 regRead && regAddr == 8'h00
      |=> regReadData == {15'h0000, $past(regWriteData[16:0], 2)})
      else $error("coefficient readback differs from write");
   a_unmapped_zero: assert property (regRead && regAddr > 8'h2c |=> regReadData == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_status_clear: assert property ((regWrite && regAddr == 8'h2c && !pixValidOut) ##1
      (regRead && regAddr == 8'h2c && !pixValidOut) |=> regReadData == 32'h0000_0000)
      else $error("pixel count not cleared by write");
   a_valid_latency: assert property (pixValidIn |-> ##5 pixValidOut)
      else $error("pixel not delivered after five cycles");
   a_no_spurious: assert property (!pixValidIn |-> ##5 !pixValidOut)
      else $error("output valid without input pixel");
   a_luma_bounds: assert property (pixValidOut |-> (UPPER_SAT == 0 || lumaOut <= lumaHi_q)
      && (LOWER_SAT == 0 || lumaOut >= lumaLo_q))
      else $error("luma outside its limits");
   a_chroma_bounds: assert property (pixValidOut |-> (UPPER_SAT == 0 ||
      (cbOut <= chromaHi_q && crOut <= chromaHi_q)) && (LOWER_SAT == 0 ||
      (cbOut >= chromaLo_q && crOut >= chromaLo_q)))
      else $error("chroma outside its limits");

   c_luma_clipped: cover property (pixValidOut && lumaOut == lumaHi_q);
   c_back_to_back: cover property (pixValidIn ##1 pixValidIn);
   c_status_read: cover property (regRead && regAddr == 8'h2c);
endmodule

bind ryc_converter ryc_converter_assertions #(.IN_W(IN_W), .OUT_W(OUT_W),
   .UPPER_SAT(UPPER_SAT), .LOWER_SAT(LOWER_SAT)) i_chk (.ref_clk(ref_clk), .resetn(resetn),
   .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .pixValidIn(pixValidIn), .pixValidOut(pixValidOut),
   .lumaOut(lumaOut), .cbOut(cbOut), .crOut(crOut));

// ---- ryc_video_model.sv ----
`timescale 1ns/10ps
module ryc_video_model
#(
   parameter IN_W  = 8,
   parameter OUT_W = 8
)
(
   // Clock.
   input  wire             ref_clk,
   // Pixels towards the converter.
   output reg              pixValidIn,
   output reg  [IN_W-1:0]  redIn,
   output reg  [IN_W-1:0]  greenIn,
   output reg  [IN_W-1:0]  blueIn,
   // Pixels from the converter.
   input  wire             pixValidOut,
   input  wire [OUT_W-1:0] lumaOut,
   input  wire [OUT_W-1:0] cbOut,
   input  wire [OUT_W-1:0] crOut
);
   logic [3*IN_W-1:0]  srcQ[$];
   logic [3*OUT_W-1:0] sinkQ[$];
   int                 gap = 0;
   int                 idleCnt = 0;

   initial
   begin
      pixValidIn = 1'b0;
      {redIn, greenIn, blueIn} = {3*IN_W{1'b0}};
   end

   // Upstream sends queued pixels with gap idle cycles between them.
   always @(posedge ref_clk)
   begin
      if (srcQ.size() > 0 && idleCnt >= gap)
      begin
         {redIn, greenIn, blueIn} <= srcQ.pop_front();
         pixValidIn <= 1'b1;
         idleCnt <= 0;
      end
      else
      begin
         // Idle data lines toggle so that a stale pixel is never reused.
         {redIn, greenIn, blueIn} <= ~{redIn, greenIn, blueIn};
         pixValidIn <= 1'b0;
         idleCnt <= idleCnt + 1;
      end
   end

   // Downstream accepts every pixel at once.
   always @(posedge ref_clk)
   begin
      if (pixValidOut === 1'b1)
         sinkQ.push_back({lumaOut, cbOut, crOut});
   end
endmodule

// ---- ryc_converter_tb.sv ----
`timescale 1ns/10ps
`include "ryc_defs.vh"
module ryc_converter_tb;
   localparam IN_W  = 8;
   localparam OUT_W = 8;
   localparam INT_W = 18;
   localparam FR    = INT_W - 2 - IN_W;
   localparam K2    = INT_W - 2 - OUT_W;

   logic              ref_clk;
   logic              resetn;
   logic [7:0]        regAddr;
   logic [31:0]       regWriteData;
   logic              regWrite;
   logic              regRead;
   logic [31:0]       regReadData;
   logic              pixValidIn;
   logic [IN_W-1:0]   redIn, greenIn, blueIn;
   logic              pixValidOut, wValid;
   logic [OUT_W-1:0]  lumaOut, cbOut, crOut, wLuma, wCb, wCr;
   logic [31:0]       shadow [0:11];
   logic [23:0]       pixQ[$];
   logic [23:0]       wrapQ[$];
   int                error_cnt = 0;
   int                check_count = 0;
   int                cycles = 0;

   ryc_converter #(.IN_W(IN_W), .OUT_W(OUT_W), .INT_W(INT_W)) i_dut (.ref_clk(ref_clk),
      .resetn(resetn), .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
      .regRead(regRead), .regReadData(regReadData), .pixValidIn(pixValidIn), .redIn(redIn),
      .greenIn(greenIn), .blueIn(blueIn), .pixValidOut(pixValidOut), .lumaOut(lumaOut),
      .cbOut(cbOut), .crOut(crOut));
   // Second build without bounding logic sees the same traffic.
   ryc_converter #(.IN_W(IN_W), .OUT_W(OUT_W), .INT_W(INT_W), .UPPER_SAT(0), .LOWER_SAT(0))
      i_wrap (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(),
      .pixValidIn(pixValidIn), .redIn(redIn), .greenIn(greenIn), .blueIn(blueIn),
      .pixValidOut(wValid), .lumaOut(wLuma), .cbOut(wCb), .crOut(wCr));
   ryc_video_model #(.IN_W(IN_W), .OUT_W(OUT_W)) i_model (.ref_clk(ref_clk),
      .pixValidIn(pixValidIn), .redIn(redIn), .greenIn(greenIn), .blueIn(blueIn),
      .pixValidOut(pixValidOut), .lumaOut(lumaOut), .cbOut(cbOut), .crOut(crOut));

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      if (wValid === 1'b1) wrapQ.push_back({wLuma, wCb, wCr});
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (error_cnt == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      if (a <= 8'h28 && a[1:0] == 2'b00)
         shadow[a >> 2] = d & ((a < 8'h10) ? 32'h0001_ffff : 32'h0000_ffff);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      regAddr <= a;
      regRead <= 1'b1;
      regWrite <= 1'b0;
      @(posedge ref_clk);
      regRead <= 1'b0;
      @(posedge ref_clk);
      chk($sformatf("register %h", a), regReadData, exp);
   endtask

   function automatic logic [23:0] expPix(input longint r, g, b, input bit sat);
      longint yr, hi, lo;
      longint v [0:2];
      logic [23:0] res;
      yr = longint'(shadow[0]) * (r - g) + longint'(shadow[1]) * (b - g);
      yr = ((yr + (64'sd1 <<< (15 - FR))) >>> (16 - FR)) + (g <<< FR);
      v[0] = ((yr + (64'sd1 <<< (K2 - 1))) >>> K2) + longint'(shadow[4]);
      v[1] = ((((b <<< FR) - yr) * longint'(shadow[2]) + (64'sd1 <<< (15 + K2))) >>> (16 + K2))
         + longint'(shadow[5]);
      v[2] = ((((r <<< FR) - yr) * longint'(shadow[3]) + (64'sd1 <<< (15 + K2))) >>> (16 + K2))
         + longint'(shadow[6]);
      for (int i = 0; i < 3; i++)
      begin
         hi = longint'(shadow[(i == 0) ? 7 : 9]);
         lo = longint'(shadow[(i == 0) ? 8 : 10]);
         if (sat && v[i] > hi) v[i] = hi;
         if (sat && v[i] < lo) v[i] = lo;
         res[23 - 8 * i -: 8] = v[i][7:0];
      end
      return res;
   endfunction

   // Sends the queued pixels, waits for all of them and compares both builds.
   task automatic send(input int gapIn);
      logic [23:0] e, w;
      int n;
      regWrite <= 1'b0;
      regRead <= 1'b0;
      n = pixQ.size();
      i_model.gap = gapIn;
      i_model.sinkQ.delete();
      wrapQ.delete();
      foreach (pixQ[i]) i_model.srcQ.push_back(pixQ[i]);
      for (int t = 0; t < 400 && i_model.sinkQ.size() < n; t++) @(posedge ref_clk);
      @(posedge ref_clk);
      chk("pixel count", i_model.sinkQ.size(), n);
      foreach (pixQ[i])
      begin
         e = expPix(pixQ[i][23:16], pixQ[i][15:8], pixQ[i][7:0], 1'b1);
         w = expPix(pixQ[i][23:16], pixQ[i][15:8], pixQ[i][7:0], 1'b0);
         chk("luma", i_model.sinkQ[i][23:16], e[23:16]);
         chk("cb", i_model.sinkQ[i][15:8], e[15:8]);
         chk("cr", i_model.sinkQ[i][7:0], e[7:0]);
         chk("wrapped pixel", wrapQ[i], w);
      end
      pixQ.delete();
   endtask

   initial
   begin
      resetn = 1'b0;
      regAddr = 8'h00;
      regWriteData = 32'h0000_0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      shadow = '{`RYC_RST_RED_COEF, `RYC_RST_BLUE_COEF, `RYC_RST_CB_COEF, `RYC_RST_CR_COEF,
         `RYC_RST_LUMA_OFS, `RYC_RST_CHROMA_OFS, `RYC_RST_CHROMA_OFS, `RYC_RST_UPPER_LIMIT,
         `RYC_RST_LOWER_LIMIT, `RYC_RST_UPPER_LIMIT, `RYC_RST_LOWER_LIMIT, 32'h0000_0000};
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int a = 0; a < 12; a++) rdchk(8'(a * 4), shadow[a]);
      rdchk(8'h30, 32'h0000_0000);
      wr(8'h30, 32'h1234_5678);
      rdchk(8'h30, 32'h0000_0000);
      wr(8'h00, 32'hffff_ffff);
      rdchk(8'h00, 32'h0001_ffff);
      wr(8'h00, `RYC_RST_RED_COEF);
      rdchk(8'h00, shadow[0]);
      pixQ = '{24'h00_0000, 24'hff_ffff, 24'hff_0000, 24'h00_00ff, 24'h00_ff00, 24'h64_32c8};
      send(0);
      wr(8'h08, 32'h0001_ffff);
      wr(8'h0c, 32'h0001_ffff);
      wr(8'h10, 32'h0000_0040);
      wr(8'h1c, 32'h0000_00eb);
      wr(8'h20, 32'h0000_0050);
      wr(8'h24, 32'h0000_00f0);
      wr(8'h28, 32'h0000_0010);
      rdchk(8'h28, 32'h0000_0010);
      pixQ = '{24'hff_ffff, 24'h00_0000, 24'h00_00ff, 24'hff_0000, 24'h80_8080};
      send(3);
      rdchk(8'h2c, 32'h0000_000b);
      wr(8'h2c, 32'hffff_ffff);
      rdchk(8'h2c, 32'h0000_0000);
      stop_test();
   end
endmodule
